// *** acc_pkg.sv ***
// Constants and types shared by the calibration control register bank
package acc_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  ACC_RUN_CTRL_IDX   = 8'h61;
    localparam logic [7:0]  ACC_CFG_A_IDX      = 8'h62;
    localparam logic [7:0]  ACC_CFG_B_IDX      = 8'h65;
    localparam logic [7:0]  ACC_STATUS_IDX     = 8'h6A;
    localparam logic [7:0]  ACC_LINK_CTRL_IDX  = 8'h7F;
    localparam logic [31:0] ACC_RUN_CTRL_ADDR  = {22'h000000, ACC_RUN_CTRL_IDX, 2'b00};
    localparam logic [31:0] ACC_CFG_A_ADDR     = {22'h000000, ACC_CFG_A_IDX, 2'b00};
    localparam logic [31:0] ACC_CFG_B_ADDR     = {22'h000000, ACC_CFG_B_IDX, 2'b00};
    localparam logic [31:0] ACC_STATUS_ADDR    = {22'h000000, ACC_STATUS_IDX, 2'b00};
    localparam logic [31:0] ACC_LINK_CTRL_ADDR = {22'h000000, ACC_LINK_CTRL_IDX, 2'b00};

    // Reset values
    localparam logic [7:0]  ACC_RUN_CTRL_RST   = 8'h01;
    localparam logic [7:0]  ACC_CFG_A_RST      = 8'h01;
    localparam logic [7:0]  ACC_CFG_B_RST      = 8'h01;
    localparam logic [7:0]  ACC_LINK_CTRL_RST  = 8'h00;

    // Field positions
    localparam int          ACC_RUN_BIT        = 0;
    localparam int          ACC_FG_BIT         = 0;
    localparam int          ACC_BG_BIT         = 1;
    localparam int          ACC_FGOS_BIT       = 2;
    localparam int          ACC_BGOS_BIT       = 3;
    localparam int          ACC_OFFSET_REFERENCE_SELECT_BIT      = 2;
    localparam int          ACC_DONE_BIT       = 0;
    localparam int          ACC_LINK_BIT       = 0;

    // Foreground pass duration
    localparam int          ACC_CLK_PERIOD_NS  = 50;
    localparam int          ACC_FG_CAL_TIME_NS = 1000;
    localparam int          ACC_FG_CAL_CYCLES  = (ACC_FG_CAL_TIME_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;
    localparam int          ACC_CNT_W          = 5;

    // AHB transfer type
    localparam logic [1:0]  ACC_HTRANS_NONSEQ  = 2'h2;

    // Register selected by an address
    typedef enum logic [2:0] {
        ACC_SEL_NONE = 3'h0,
        ACC_SEL_RUN  = 3'h1,
        ACC_SEL_CFGA = 3'h2,
        ACC_SEL_CFGB = 3'h3,
        ACC_SEL_STAT = 3'h4,
        ACC_SEL_LINK = 3'h5
    } acc_sel_e;

    // Engine states, Gray along hold, clear, foreground, running
    typedef enum logic [1:0] {
        ACC_ST_HOLD  = 2'b00,
        ACC_ST_CLEAR = 2'b01,
        ACC_ST_FG    = 2'b11,
        ACC_ST_RUN   = 2'b10
    } acc_state_e;

endpackage

// *** acc_engine.sv ***
// Calibration engine sequencer: hold, clear values, foreground pass, running
`timescale 1ns/1ps
module acc_engine
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    // Control and configuration
    input  wire logic i_run,
    input  wire logic i_fg,
    input  wire logic i_bg,
    input  wire logic i_fgos,
    input  wire logic i_bgos,
    input  wire logic i_offset_reference_select,
    // Engine state
    output logic      o_done,
    output logic      o_clear_values,
    output logic      o_fg_active,
    output logic      o_bg_active,
    output logic      o_fgos_active,
    output logic      o_bgos_active,
    output logic      o_ref_spare
);

    acc_state_e             state_r;
    logic [ACC_CNT_W-1:0]   cnt_r;
    logic                   fg_r;
    logic                   bg_r;
    logic                   fgos_r;
    logic                   bgos_r;
    logic                   offset_reference_select_r;

    // Sequencer; a low run bit forces hold from any state
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= ACC_ST_HOLD;
            cnt_r   <= '0;
        end else if (!i_run) begin
            state_r <= ACC_ST_HOLD;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ACC_ST_HOLD: begin
                    state_r <= ACC_ST_CLEAR;
                end
                ACC_ST_CLEAR: begin
                    cnt_r   <= ACC_CNT_W'(ACC_FG_CAL_CYCLES - 1);
                    state_r <= fg_r ? ACC_ST_FG : ACC_ST_RUN;
                end
                ACC_ST_FG: begin
                    if (cnt_r == '0) begin
                        state_r <= ACC_ST_RUN;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ACC_ST_RUN: begin
                    state_r <= ACC_ST_RUN;
                end
                default: begin
                    state_r <= ACC_ST_HOLD;
                end
            endcase
        end
    end

    // Settings are captured only when leaving hold
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fg_r    <= 1'b1;
            bg_r    <= 1'b0;
            fgos_r  <= 1'b0;
            bgos_r  <= 1'b0;
            offset_reference_select_r <= 1'b0;
        end else if (state_r == ACC_ST_HOLD && i_run) begin
            fg_r    <= i_fg;
            bg_r    <= i_bg;
            fgos_r  <= i_fgos;
            bgos_r  <= i_bgos;
            offset_reference_select_r <= i_offset_reference_select;
        end
    end

    // Registered outputs derived from state and captured settings
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_done         <= 1'b0;
            o_clear_values <= 1'b0;
            o_fg_active    <= 1'b0;
            o_bg_active    <= 1'b0;
            o_fgos_active  <= 1'b0;
            o_bgos_active  <= 1'b0;
            o_ref_spare    <= 1'b0;
        end else begin
            o_done         <= i_run && (state_r == ACC_ST_RUN);
            o_clear_values <= i_run && (state_r == ACC_ST_CLEAR);
            o_fg_active    <= i_run && (state_r == ACC_ST_FG);
            o_bg_active    <= i_run && (state_r == ACC_ST_RUN) && bg_r;
            o_fgos_active  <= i_run && (state_r == ACC_ST_FG) && fgos_r;
            o_bgos_active  <= i_run && (state_r == ACC_ST_RUN) && bg_r && bgos_r;
            o_ref_spare    <= offset_reference_select_r;
        end
    end

    // Checks on the sequencer
    chk_hold_when_low: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !i_run |=> (state_r == ACC_ST_HOLD) && !o_done ##1 !o_fg_active && !o_bg_active)
        else $error("engine not held while run bit low");

    chk_skip_to_done: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state_r == ACC_ST_CLEAR) && !fg_r && i_run ##1 i_run |-> ##1 o_done)
        else $error("skipped foreground did not complete");

    chk_fg_length: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        $rose(o_fg_active) |-> (o_fg_active || !i_run)[*8])
        else $error("foreground pass ended too early");

    chk_bgos_gated: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_bgos_active |-> o_bg_active)
        else $error("background offset active without background");

    chk_fgos_gated: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_fgos_active |-> o_fg_active && fg_r)
        else $error("foreground offset active without foreground");

    chk_cfg_frozen: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state_r != ACC_ST_HOLD) |=> $stable(fg_r) && $stable(bg_r) && $stable(offset_reference_select_r))
        else $error("settings changed while running");

endmodule

// *** acc_cal_regs.sv ***
// Calibration control register bank with AHB-Lite slave and engine
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module acc_cal_regs
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic [31:0]      o_hrdata,
    output logic             o_hresp,
    // Clocking and link control
    output logic             o_cal_run,
    output logic             o_divider_reset,
    output logic             o_serial_link_enable,
    // Calibration engine state
    output logic             o_cal_clear_values,
    output logic             o_fg_cal_active,
    output logic             o_bg_cal_active,
    output logic             o_fg_offset_active,
    output logic             o_bg_offset_active,
    output logic             o_offset_ref_spare,
    output logic             o_foreground_complete
);

    // Address decode shared by read and write paths
    function automatic acc_sel_e acc_decode(input logic [31:0] addr);
        acc_sel_e sel;
        sel = ACC_SEL_NONE;
        case (addr)
            ACC_RUN_CTRL_ADDR:  sel = ACC_SEL_RUN;
            ACC_CFG_A_ADDR:     sel = ACC_SEL_CFGA;
            ACC_CFG_B_ADDR:     sel = ACC_SEL_CFGB;
            ACC_STATUS_ADDR:    sel = ACC_SEL_STAT;
            ACC_LINK_CTRL_ADDR: sel = ACC_SEL_LINK;
            default:            sel = ACC_SEL_NONE;
        endcase
        return sel;
    endfunction

    logic [7:0]  run_ctrl_r;
    logic [7:0]  cfg_a_r;
    logic [7:0]  cfg_b_r;
    logic [7:0]  link_ctrl_r;
    logic        wr_pend_r;
    acc_sel_e    wr_sel_r;
    logic        addr_ok;
    acc_sel_e    addr_sel;
    logic [7:0]  rd_byte;
    logic        eng_done;
    logic        eng_clear;
    logic        eng_fg;
    logic        eng_bg;
    logic        eng_fgos;
    logic        eng_bgos;
    logic        eng_ref;

    // Address phase qualification
    assign addr_ok  = i_hsel && i_hready && (i_htrans == ACC_HTRANS_NONSEQ);
    assign addr_sel = acc_decode(i_haddr);

    // Read multiplexer, unmapped addresses read zero; reserved bits read back as stored, except status reserved bits, which read zero
    always_comb begin
        rd_byte = 8'h00;
        case (addr_sel)
            ACC_SEL_RUN:  rd_byte = run_ctrl_r;
            ACC_SEL_CFGA: rd_byte = cfg_a_r;
            ACC_SEL_CFGB: rd_byte = cfg_b_r;
            ACC_SEL_STAT: rd_byte = {7'h00, eng_done};
            ACC_SEL_LINK: rd_byte = link_ctrl_r;
            default:      rd_byte = 8'h00;
        endcase
    end

    // Write address held for the following data phase
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_r <= 1'b0;
            wr_sel_r  <= ACC_SEL_NONE;
        end else if (i_hready) begin
            wr_pend_r <= addr_ok && i_hwrite;
            wr_sel_r  <= addr_sel;
        end
    end

    // Read data captured at the address phase, valid in the data phase
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_ok && !i_hwrite) begin
            o_hrdata <= {24'h000000, rd_byte};
        end
    end

    // Zero wait states and OKAY response always
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    // Run control register; reset value lets calibration run
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_ctrl_r <= ACC_RUN_CTRL_RST;
        end else if (wr_pend_r && wr_sel_r == ACC_SEL_RUN) begin
            run_ctrl_r <= i_hwdata[7:0];
        end
    end

    // First configuration register
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_a_r <= ACC_CFG_A_RST;
        end else if (wr_pend_r && wr_sel_r == ACC_SEL_CFGA) begin
            cfg_a_r <= i_hwdata[7:0];
        end
    end

    // Second configuration register; reserved low bits reset to 01
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_b_r <= ACC_CFG_B_RST;
        end else if (wr_pend_r && wr_sel_r == ACC_SEL_CFGB) begin
            cfg_b_r <= i_hwdata[7:0];
        end
    end

    // Serial link enable register; ordering against run is software's duty
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_ctrl_r <= ACC_LINK_CTRL_RST;
        end else if (wr_pend_r && wr_sel_r == ACC_SEL_LINK) begin
            link_ctrl_r <= i_hwdata[7:0];
        end
    end

    // Run level and divider reset outputs
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cal_run            <= 1'b0;
            o_divider_reset      <= 1'b1;
            o_serial_link_enable <= 1'b0;
        end else begin
            o_cal_run            <= run_ctrl_r[ACC_RUN_BIT];
            o_divider_reset      <= !run_ctrl_r[ACC_RUN_BIT];
            o_serial_link_enable <= link_ctrl_r[ACC_LINK_BIT];
        end
    end

    // Calibration engine
    acc_engine u_engine (
        .i_clock        (i_clock),
        .i_arst_n       (i_arst_n),
        .i_run          (run_ctrl_r[ACC_RUN_BIT]),
        .i_fg           (cfg_a_r[ACC_FG_BIT]),
        .i_bg           (cfg_a_r[ACC_BG_BIT]),
        .i_fgos         (cfg_a_r[ACC_FGOS_BIT]),
        .i_bgos         (cfg_a_r[ACC_BGOS_BIT]),
        .i_offset_reference_select        (cfg_b_r[ACC_OFFSET_REFERENCE_SELECT_BIT]),
        .o_done         (eng_done),
        .o_clear_values (eng_clear),
        .o_fg_active    (eng_fg),
        .o_bg_active    (eng_bg),
        .o_fgos_active  (eng_fgos),
        .o_bgos_active  (eng_bgos),
        .o_ref_spare    (eng_ref)
    );

    // Engine state outputs, straight from the engine's flops
    assign o_cal_clear_values    = eng_clear;
    assign o_fg_cal_active       = eng_fg;
    assign o_bg_cal_active       = eng_bg;
    assign o_fg_offset_active    = eng_fgos;
    assign o_bg_offset_active    = eng_bgos;
    assign o_offset_ref_spare    = eng_ref;
    assign o_foreground_complete = eng_done;

    // Checks on the register bank
    chk_divider_reset_low: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !run_ctrl_r[ACC_RUN_BIT] |=> o_divider_reset && !o_cal_run)
        else $error("dividers not reset while run bit low");

    chk_run_level_out: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        $rose(run_ctrl_r[ACC_RUN_BIT]) |=> o_cal_run && !o_divider_reset ##1 !o_foreground_complete)
        else $error("run output did not follow run bit");

    chk_run_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        wr_pend_r && wr_sel_r == ACC_SEL_RUN |=> run_ctrl_r == $past(i_hwdata[7:0]))
        else $error("run control write lost");

    chk_cfg_a_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        wr_pend_r && wr_sel_r == ACC_SEL_CFGA |=> cfg_a_r == $past(i_hwdata[7:0]))
        else $error("first configuration write lost");

    chk_status_read: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        addr_ok && !i_hwrite && addr_sel == ACC_SEL_STAT |=> o_hrdata == {31'h0, $past(eng_done)})
        else $error("status read does not show completion flag");

    chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        addr_ok && !i_hwrite && addr_sel == ACC_SEL_NONE |=> o_hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_bus_ready: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_hreadyout && !o_hresp)
        else $error("slave stalled or answered error");

    chk_done_cleared: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        $fell(run_ctrl_r[ACC_RUN_BIT]) |-> ##1 !o_foreground_complete ##1 !o_bg_cal_active)
        else $error("completion flag survived run bit clear");

endmodule

// *** adc_calibration_control_test.sv ***
// Self-checking bench for the calibration control register bank
`timescale 1ns/1ps
module adc_calibration_control_test
    import acc_pkg::*;
;
    typedef struct {
        int         c;
        logic [8:0] v;
        logic [8:0] m;
    } acc_note_s;

    // Stimulus and observed signals
    logic        i_clock  = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_hsel   = 1'b1;
    logic [31:0] i_haddr  = 32'h00000000;
    logic [1:0]  i_htrans = 2'h0;
    logic        i_hwrite = 1'b0;
    logic [2:0]  i_hsize  = 3'h2;
    logic [31:0] i_hwdata = 32'h00000000;
    logic        i_hready;
    logic [31:0] o_hrdata;
    logic        o_hreadyout, o_hresp, o_cal_run, o_divider_reset, o_serial_link_enable, o_cal_clear_values;
    logic        o_fg_cal_active, o_bg_cal_active, o_fg_offset_active, o_bg_offset_active;
    logic        o_offset_ref_spare, o_foreground_complete;
    logic [8:0]  sig;

    // Bookkeeping
    int          miscompares = 0;
    int          tests_run = 0;
    int          seed = 30;
    int          cyc = 0;
    int          exp_c;
    logic [31:0] exp_rd;
    logic        rd_pend = 1'b0;
    logic        done_prev = 1'b0;
    acc_note_s   nt;
    acc_note_s   st_q[$];
    logic [31:0] rd_q[$];
    int          clr_q[$];
    int          done_q[$];

    // The single slave drives the bus ready
    assign i_hready = o_hreadyout;
    // Level outputs packed run, divider reset, link, fg, fg offset, bg, bg offset, spare, done
    assign sig = {o_cal_run, o_divider_reset, o_serial_link_enable, o_fg_cal_active, o_fg_offset_active,
                  o_bg_cal_active, o_bg_offset_active, o_offset_ref_spare, o_foreground_complete};

    acc_cal_regs uut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
        .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
        .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .o_cal_run(o_cal_run),
        .o_divider_reset(o_divider_reset), .o_serial_link_enable(o_serial_link_enable),
        .o_cal_clear_values(o_cal_clear_values), .o_fg_cal_active(o_fg_cal_active),
        .o_bg_cal_active(o_bg_cal_active), .o_fg_offset_active(o_fg_offset_active),
        .o_bg_offset_active(o_bg_offset_active), .o_offset_ref_spare(o_offset_ref_spare),
        .o_foreground_complete(o_foreground_complete)
    );

    // Clock, 50 ns period
    always #25 i_clock = ~i_clock;

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize;
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Wait for hready under a bound
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 16);
        if (o_hreadyout !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask

    // One single-word transfer; e is the cycle stamp of the data phase edge
    task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d, output int e);
        logic [31:0] r;
        r = $random(seed);
        i_haddr  <= a;
        i_htrans <= ACC_HTRANS_NONSEQ;
        i_hwrite <= w;
        wait_ready();
        i_htrans <= 2'h0;
        i_hwdata <= {r[31:8], d};
        wait_ready();
        e = cyc;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d, output int e);
        bus(a, 1'b1, d, e);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        int e;
        rd_q.push_back(exp);
        bus(a, 1'b0, 8'h00, e);
    endtask

    task automatic note(input int c, input logic [8:0] v, input logic [8:0] m);
        st_q.push_back('{c, v, m});
    endtask

    // Watcher: matches each observed result against the oldest note
    always @(posedge i_clock) begin
        if (rd_pend && o_hreadyout === 1'b1) begin
            exp_rd = rd_q.size() > 0 ? rd_q.pop_front() : 32'hFFFFFFFF;
            check(o_hrdata, exp_rd);
            check({31'h00000000, o_hresp}, 32'h00000000);
        end
        if (o_cal_clear_values === 1'b1) begin
            exp_c = clr_q.size() > 0 ? clr_q.pop_front() : -1;
            check(32'(cyc), 32'(exp_c));
        end
        if (o_foreground_complete === 1'b1 && done_prev !== 1'b1) begin
            exp_c = done_q.size() > 0 ? done_q.pop_front() : -1;
            check(32'(cyc), 32'(exp_c));
        end
        while (st_q.size() > 0 && st_q[0].c == cyc) begin
            nt = st_q.pop_front();
            check({23'h000000, sig & nt.m}, {23'h000000, nt.v & nt.m});
        end
        rd_pend <= (i_hsel && i_htrans == ACC_HTRANS_NONSEQ && !i_hwrite && o_hreadyout) || (rd_pend && !o_hreadyout);
        done_prev <= o_foreground_complete;
        cyc <= cyc + 1;
    end

    // Main sequence
    initial begin
        int         e;
        int         r;
        logic [3:0] cfg;
        logic       os;
        repeat (2) @(posedge i_clock);
        note(cyc + 1, 9'h080, 9'h1FF);
        @(posedge i_clock);
        i_arst_n <= 1'b1;
        r = cyc;
        clr_q.push_back(r + 3);
        done_q.push_back(r + 24);
        note(r + 12, 9'h120, 9'h1F0);
        rd(ACC_RUN_CTRL_ADDR, 32'h00000001);
        rd(ACC_CFG_A_ADDR, 32'h00000001);
        rd(ACC_CFG_B_ADDR, 32'h00000001);
        rd(ACC_LINK_CTRL_ADDR, 32'h00000000);
        rd(ACC_STATUS_ADDR, 32'h00000000);
        wr(32'h00000180, 8'hA5, e);
        rd(32'h00000180, 32'h00000000);
        repeat (20) @(posedge i_clock);
        rd(ACC_STATUS_ADDR, 32'h00000001);
        wr(ACC_LINK_CTRL_ADDR, 8'h01, e);
        note(e + 3, 9'h141, 9'h1C1);
        rd(ACC_LINK_CTRL_ADDR, 32'h00000001);
        wr(ACC_LINK_CTRL_ADDR, 8'h00, e);
        for (int i = 0; i < 32; i++) begin
            cfg = i[3:0];
            os = i[4] & cfg[1];
            wr(ACC_RUN_CTRL_ADDR, 8'h00, e);
            note(e + 4, 9'h080, 9'h1FD);
            wr(ACC_CFG_A_ADDR, {4'h0, cfg}, e);
            wr(ACC_CFG_B_ADDR, {5'h00, os, 2'b01}, e);
            // Flag drops a cycle after the run bit, so read it once the writes are done
            rd(ACC_STATUS_ADDR, 32'h00000000);
            rd(ACC_CFG_A_ADDR, {28'h0000000, cfg});
            rd(ACC_CFG_B_ADDR, {29'h00000000, os, 2'b01});
            wr(ACC_RUN_CTRL_ADDR, 8'h01, e);
            clr_q.push_back(e + 3);
            done_q.push_back(cfg[0] ? e + 24 : e + 4);
            if (cfg[0]) begin
                note(e + 12, {4'h9, cfg[2], 4'h0}, 9'h1F0);
            end
            note(e + 30, {5'h10, cfg[1], cfg[1] & cfg[3], os, 1'b1}, 9'h1FF);
            wr(ACC_CFG_A_ADDR, {4'h0, ~cfg}, e);
            repeat (30) @(posedge i_clock);
        end
        repeat (40) @(posedge i_clock);
        check(32'(st_q.size() + clr_q.size() + done_q.size() + rd_q.size()), 32'h00000000);
        summarize();
    end

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge i_clock);
        miscompares++;
        summarize();
    end
endmodule
